/* File: eid_core.sv */
// Decode and execute for test-skip, xor and extended instructions
`timescale 1ns/1ps
module eid_core
  import eid_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Program memory, read in the same cycle
  output logic [20:0]            progAddr,
  input  wire logic [15:0]       progData,
  // Data memory, read in the same cycle, written at the edge
  output logic [11:0]            dmemAddr,
  input  wire logic [7:0]        dmemRdData,
  output logic [7:0]             dmemWrData,
  output logic                   dmemWrEn
);
  // Architectural state
  logic [1:0]  ctrl_q,  ctrl_d;
  logic [7:0]  acc_q,   acc_d;
  logic [7:0]  bank_q,  bank_d;
  logic [1:0]  stat_q,  stat_d;
  logic [20:0] pc_q,    pc_d;
  logic [11:0] ptr_q [3];
  logic [11:0] ptr_d [3];
  logic [7:0]  latH_q,  latH_d;
  logic [7:0]  latU_q,  latU_d;
  logic [7:0]  moveData_q, moveData_d;
  logic        moveAbs_q,  moveAbs_d;
  eid_state_t  state_q, state_d;

  // Bus side state
  logic [AXI_AW-1:0] awAddr_q, awAddr_d;
  logic              awHave_q, awHave_d;
  logic [31:0]       wData_q,  wData_d;
  logic [3:0]        wStrb_q,  wStrb_d;
  logic              wHave_q,  wHave_d;
  logic              bValid_q, bValid_d;
  logic [1:0]        bResp_q,  bResp_d;
  logic              rValid_q, rValid_d;
  logic [31:0]       rData_q,  rData_d;
  logic [1:0]        rResp_q,  rResp_d;

  logic        swWr;
  logic        extOn;
  logic        running;
  logic [11:0] fileAddr;
  logic        rsPush;
  logic        rsPop;
  logic [20:0] rsHead;
  logic [20:0] pcNext;

  assign extOn   = ctrl_q[CTRL_EXT_BIT];
  assign running = ctrl_q[CTRL_RUN_BIT];
  assign pcNext  = pc_q + PC_STEP;
  assign progAddr = pc_q;

  eid_file_addr u_addr (
    .fileOp      (progData[7:0]),
    .accessSel   (progData[8]),
    .bankSel     (bank_q[3:0]),
    .extEnable   (extOn),
    .stackPtr    (ptr_q[2]),
    .fileAddr    (fileAddr),
    .indexedMode ()
  );

  eid_return_stack #(
    .DEPTH (STACK_DEPTH),
    .PC_W  (21)
  ) u_stack (
    .clk      (clk),
    .srst     (srst),
    .push     (rsPush),
    .pop      (rsPop),
    .pushData (pcNext),
    .head     (rsHead)
  );

  // Bus write/read sequencing; address and data taken in either order
  always_comb begin
    awAddr_d = awAddr_q;
    awHave_d = awHave_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    wHave_d  = wHave_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    s_axi_awready = !awHave_q && !bValid_q;
    s_axi_wready  = !wHave_q && !bValid_q;
    s_axi_arready = !rValid_q;
    swWr = awHave_q && wHave_q && !bValid_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_d = s_axi_awaddr;
      awHave_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
      wHave_d = 1'b1;
    end
    if (swWr) begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = RESP_OKAY;
      if (awAddr_q == OFF_STATUS || awAddr_q == OFF_PC || awAddr_q > OFF_LATCH ||
          awAddr_q[1:0] != 2'h0) begin
        bResp_d = RESP_SLVERR;
      end
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rResp_d  = RESP_OKAY;
      rData_d  = 32'h00000000;
      if (s_axi_araddr == OFF_CTRL) begin
        rData_d = {30'h0, ctrl_q};
      end else if (s_axi_araddr == OFF_ACC) begin
        rData_d = {24'h0, acc_q};
      end else if (s_axi_araddr == OFF_BANK) begin
        rData_d = {24'h0, bank_q};
      end else if (s_axi_araddr == OFF_STATUS) begin
        rData_d = {30'h0, stat_q};
      end else if (s_axi_araddr == OFF_PC) begin
        rData_d = {11'h0, pc_q};
      end else if (s_axi_araddr == OFF_PTR0) begin
        rData_d = {20'h0, ptr_q[0]};
      end else if (s_axi_araddr == OFF_PTR1) begin
        rData_d = {20'h0, ptr_q[1]};
      end else if (s_axi_araddr == OFF_PTR2) begin
        rData_d = {20'h0, ptr_q[2]};
      end else if (s_axi_araddr == OFF_LATCH) begin
        rData_d = {16'h0, latU_q, latH_q};
      end else begin
        rResp_d = RESP_SLVERR;
      end
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awAddr_q <= '0;
      awHave_q <= 1'b0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      wHave_q  <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= RESP_OKAY;
    end else begin
      awAddr_q <= awAddr_d;
      awHave_q <= awHave_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      wHave_q  <= wHave_d;
      bValid_q <= bValid_d;
      bResp_q  <= bResp_d;
      rValid_q <= rValid_d;
      rData_q  <= rData_d;
      rResp_q  <= rResp_d;
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp  = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata  = rData_q;
  assign s_axi_rresp  = rResp_q;

  // Execute one program word per cycle while running
  always_comb begin
    logic [7:0]  xorRes;
    logic [1:0]  sel;
    logic [11:0] lit;
    logic [11:0] dst;
    xorRes     = acc_q ^ dmemRdData;
    sel        = progData[7:6];
    lit        = {6'h00, progData[5:0]};
    dst        = 12'h000;
    ctrl_d     = ctrl_q;
    acc_d      = acc_q;
    bank_d     = bank_q;
    stat_d     = stat_q;
    pc_d       = pc_q;
    ptr_d      = ptr_q;
    latH_d     = latH_q;
    latU_d     = latU_q;
    moveData_d = moveData_q;
    moveAbs_d  = moveAbs_q;
    state_d    = state_q;
    rsPush     = 1'b0;
    rsPop      = 1'b0;
    dmemAddr   = fileAddr;
    dmemWrData = 8'h00;
    dmemWrEn   = 1'b0;
    if (running) begin
      pc_d = pcNext;
      case (state_q)
        EID_SKIP: begin
          // Discarded word; a two-word one costs a further cycle
          state_d = isTwoWord(progData) ? EID_SKIP2 : EID_EXEC;
        end
        EID_SKIP2: begin
          state_d = EID_EXEC;
        end
        EID_BUBBLE: begin
          // New target is fetched here, so the pc holds
          pc_d    = pc_q;
          state_d = EID_EXEC;
        end
        EID_MOVE2: begin
          state_d = EID_EXEC;
          dst = moveAbs_q ? progData[11:0] : ptr_q[2] + {5'h00, progData[6:0]};
          dmemAddr   = dst;
          dmemWrData = moveData_q;
          dmemWrEn   = moveAbs_q || !isIndirect(dst);
        end
        default: begin
          if (progData[15:9] == OP_TEST_SKIP) begin
            if (dmemRdData == 8'h00) begin
              state_d = EID_SKIP;
            end
          end else if (progData[15:8] == OP_XOR_LIT) begin
            acc_d = acc_q ^ progData[7:0];
            stat_d[STAT_Z_BIT] = (acc_d == 8'h00);
            stat_d[STAT_N_BIT] = acc_d[7];
          end else if (progData[15:10] == OP_XOR_FILE) begin
            if (progData[9]) begin
              dmemWrData = xorRes;
              dmemWrEn   = 1'b1;
            end else begin
              acc_d = xorRes;
            end
            stat_d[STAT_Z_BIT] = (xorRes == 8'h00);
            stat_d[STAT_N_BIT] = xorRes[7];
          end else if (extOn) begin
            if (progData[15:9] == OP_PTR_ADD[7:1]) begin
              if (sel == SEL_STACK) begin
                ptr_d[2] = progData[8] ? ptr_q[2] - lit : ptr_q[2] + lit;
                pc_d     = rsHead;
                rsPop    = 1'b1;
                state_d  = EID_BUBBLE;
              end else begin
                ptr_d[sel] = progData[8] ? ptr_q[sel] - lit : ptr_q[sel] + lit;
              end
            end else if (progData == OP_CALL_ACC) begin
              rsPush  = 1'b1;
              pc_d    = {latU_q[4:0], latH_q, acc_q};
              state_d = EID_BUBBLE;
            end else if (progData[15:8] == OP_PUSH_LIT) begin
              dmemAddr   = ptr_q[2];
              dmemWrData = progData[7:0];
              dmemWrEn   = 1'b1;
              ptr_d[2]   = ptr_q[2] - 12'h001;
            end else if (progData[15:8] == OP_MOVE_IDX) begin
              dmemAddr   = ptr_q[2] + {5'h00, progData[6:0]};
              moveData_d = isIndirect(dmemAddr) ? 8'h00 : dmemRdData;
              moveAbs_d  = !progData[7];
              state_d    = EID_MOVE2;
            end
          end
        end
      endcase
    end
    // Software writes override the core in the same cycle
    if (swWr && wStrb_q[0]) begin
      if (awAddr_q == OFF_CTRL) begin
        ctrl_d = wData_q[1:0];
      end else if (awAddr_q == OFF_ACC) begin
        acc_d = wData_q[7:0];
      end else if (awAddr_q == OFF_BANK) begin
        bank_d = wData_q[7:0];
      end else if (awAddr_q == OFF_PTR0) begin
        ptr_d[0] = {wStrb_q[1] ? wData_q[11:8] : ptr_q[0][11:8], wData_q[7:0]};
      end else if (awAddr_q == OFF_PTR1) begin
        ptr_d[1] = {wStrb_q[1] ? wData_q[11:8] : ptr_q[1][11:8], wData_q[7:0]};
      end else if (awAddr_q == OFF_PTR2) begin
        ptr_d[2] = {wStrb_q[1] ? wData_q[11:8] : ptr_q[2][11:8], wData_q[7:0]};
      end else if (awAddr_q == OFF_LATCH) begin
        latH_d = wData_q[7:0];
        latU_d = wStrb_q[1] ? wData_q[15:8] : latU_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q     <= CTRL_RESET;
      acc_q      <= BYTE_RESET;
      bank_q     <= BYTE_RESET;
      stat_q     <= 2'h0;
      pc_q       <= PC_RESET;
      ptr_q      <= '{PTR_RESET, PTR_RESET, PTR_RESET};
      latH_q     <= BYTE_RESET;
      latU_q     <= BYTE_RESET;
      moveData_q <= BYTE_RESET;
      moveAbs_q  <= 1'b0;
      state_q    <= EID_EXEC;
    end else begin
      ctrl_q     <= ctrl_d;
      acc_q      <= acc_d;
      bank_q     <= bank_d;
      stat_q     <= stat_d;
      pc_q       <= pc_d;
      ptr_q      <= ptr_d;
      latH_q     <= latH_d;
      latU_q     <= latU_d;
      moveData_q <= moveData_d;
      moveAbs_q  <= moveAbs_d;
      state_q    <= state_d;
    end
  end
endmodule

/* File: eid_core_props.sv */
// Port checker for the extended instruction decoder
`timescale 1ns/1ps
module eid_core_props
  import eid_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [20:0] progAddr,
  input wire logic [15:0] progData,
  input wire logic [7:0]  dmemRdData,
  input wire logic [7:0]  dmemWrData,
  input wire logic        dmemWrEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Write answer two edges after the take, read answer one; both stand until accepted
  bresp_after_write_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |=> ##1 s_axi_bvalid) else $error("write response not given");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
  rdata_after_addr_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not given");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
  arready_free_a:
    assert property (s_axi_arready == !s_axi_rvalid) else $error("read address ready wrong");
  reset_idle_a:
    assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && progAddr == PC_RESET)
      else $error("not idle after reset");
  // A taken skip must not let the discarded word write memory
  skip_discard_a:
    assert property (progData[15:9] == OP_TEST_SKIP && dmemRdData == 8'h00
                     ##1 progAddr != $past(progAddr) |-> !dmemWrEn) else $error("skipped word ran");
  push_literal_a:
    assert property (dmemWrEn && progData[15:8] == OP_PUSH_LIT |-> dmemWrData == progData[7:0])
      else $error("pushed byte wrong");
  // The call holds its target fetch one cycle as a bubble
  call_bubble_a:
    assert property (progData == OP_CALL_ACC ##1 progAddr != $past(progAddr)
                     |=> progAddr == $past(progAddr)) else $error("call bubble missing");
  xor_lit_quiet_a:
    assert property (progData[15:8] == OP_XOR_LIT |-> !dmemWrEn) else $error("xor literal wrote");

  cover property (progData[15:9] == OP_TEST_SKIP && dmemRdData == 8'h00);
  cover property (progData == OP_CALL_ACC);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

/* File: eid_file_addr.sv */
// Effective data address of a byte-oriented file operand
`timescale 1ns/1ps
module eid_file_addr
  import eid_pkg::*;
(
  input  wire logic [7:0]  fileOp,
  input  wire logic        accessSel,
  input  wire logic [3:0]  bankSel,
  input  wire logic        extEnable,
  input  wire logic [11:0] stackPtr,
  output logic      [11:0] fileAddr,
  output logic             indexedMode
);
  // Indexed mode only below the split, only with the extension on
  always_comb begin
    indexedMode = !accessSel && extEnable && (fileOp <= INDEXED_MAX);
    if (accessSel) begin
      fileAddr = {bankSel, fileOp};
    end else if (indexedMode) begin
      fileAddr = stackPtr + {4'h0, fileOp};
    end else if (fileOp < ACCESS_SPLIT) begin
      fileAddr = {ACCESS_LOBNK, fileOp};
    end else begin
      fileAddr = {ACCESS_HIBNK, fileOp};
    end
  end
endmodule

/* File: eid_mem_model.sv */
// Program and data memory beside the decoder, both read in the same cycle
`timescale 1ns/1ps
module eid_mem_model (
  input  wire logic        clk,
  input  wire logic [20:0] progAddr,
  output logic      [15:0] progData,
  input  wire logic [11:0] dmemAddr,
  output logic      [7:0]  dmemRdData,
  input  wire logic [7:0]  dmemWrData,
  input  wire logic        dmemWrEn
);
  logic [15:0] prog [0:1023];
  logic [7:0]  dmem [0:4095];
  // Fetches past the loaded image see no-operations
  assign progData = (progAddr[20:11] == 10'h000) ? prog[progAddr[10:1]] : 16'h0000;
  assign dmemRdData = dmem[dmemAddr];
  // Writes land at the edge, like a synchronous RAM
  always @(posedge clk) begin
    if (dmemWrEn) begin
      dmem[dmemAddr] <= dmemWrData;
    end
  end
endmodule

/* File: eid_pkg.sv */
// Shared constants, types and decode helpers for the extended instruction decoder
package eid_pkg;

  // Register bus geometry and answers
  localparam int         AXI_AW      = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ACC    = 8'h04;
  localparam logic [7:0] OFF_BANK   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_PTR0   = 8'h14;
  localparam logic [7:0] OFF_PTR1   = 8'h18;
  localparam logic [7:0] OFF_PTR2   = 8'h1C;
  localparam logic [7:0] OFF_LATCH  = 8'h20;

  // Field positions and reset values
  localparam int         CTRL_EXT_BIT = 0;
  localparam int         CTRL_RUN_BIT = 1;
  localparam int         STAT_Z_BIT   = 0;
  localparam int         STAT_N_BIT   = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [11:0] PTR_RESET   = 12'h000;
  localparam logic [20:0] PC_RESET    = 21'h000000;
  localparam logic [20:0] PC_STEP     = 21'h000002;

  // Opcode fields
  localparam logic [6:0]  OP_TEST_SKIP = 7'h33;
  localparam logic [7:0]  OP_XOR_LIT   = 8'h0A;
  localparam logic [5:0]  OP_XOR_FILE  = 6'h06;
  localparam logic [7:0]  OP_PTR_ADD   = 8'hE8;
  localparam logic [7:0]  OP_PTR_SUB   = 8'hE9;
  localparam logic [7:0]  OP_PUSH_LIT  = 8'hEA;
  localparam logic [7:0]  OP_MOVE_IDX  = 8'hEB;
  localparam logic [15:0] OP_CALL_ACC  = 16'h0014;
  localparam logic [3:0]  PFX_SECOND   = 4'hF;
  localparam logic [3:0]  PFX_MOVE_ABS = 4'hC;
  localparam logic [6:0]  PFX_CALL     = 7'h76;
  localparam logic [6:0]  PFX_LOAD_JMP = 7'h77;
  localparam logic [1:0]  SEL_STACK    = 2'h3;

  // Addressing constants
  localparam logic [7:0]  INDEXED_MAX  = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_LOBNK = 4'h0;
  localparam logic [3:0]  ACCESS_HIBNK = 4'hF;
  localparam logic [11:0] IND_ADDR0    = 12'hFEF;
  localparam logic [11:0] IND_ADDR1    = 12'hFE7;
  localparam logic [11:0] IND_ADDR2    = 12'hFDF;

  typedef enum logic [2:0] {
    EID_EXEC,
    EID_SKIP,
    EID_SKIP2,
    EID_BUBBLE,
    EID_MOVE2
  } eid_state_t;

  // First word of any two-word instruction
  function automatic logic isTwoWord(input logic [15:0] w);
    isTwoWord = (w[15:12] == PFX_MOVE_ABS) || (w[15:9] == PFX_CALL) ||
                (w[15:9] == PFX_LOAD_JMP) || (w[15:8] == OP_MOVE_IDX);
  endfunction

  // Data address that maps onto an indirect access register
  function automatic logic isIndirect(input logic [11:0] a);
    isIndirect = (a == IND_ADDR0) || (a == IND_ADDR1) || (a == IND_ADDR2);
  endfunction

endpackage

/* File: eid_return_stack.sv */
// Hardware return stack for calls and returns
`timescale 1ns/1ps
module eid_return_stack
  import eid_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int PC_W  = 21
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] pushData,
  output logic      [PC_W-1:0] head
);
  localparam int PW = $clog2(DEPTH) + 1;

  logic [PC_W-1:0] mem [DEPTH];
  logic [PW-1:0]   ptr_q;
  logic [PW-1:0]   ptr_d;

  // Overflow wraps; the head simply reads stale data, as a small core would
  always_comb begin
    ptr_d = ptr_q;
    if (push) begin
      ptr_d = ptr_q + PW'(1);
    end else if (pop && ptr_q != '0) begin
      ptr_d = ptr_q - PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
    if (push) begin
      mem[ptr_q[PW-2:0]] <= pushData;
    end
  end

  // Low pointer bits wrap with the power-of-two depth
  assign head = mem[ptr_q[PW-2:0] - (PW-1)'(1)];
endmodule

/* File: tb.sv */
// Self-checking bench for the extended instruction decoder
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import eid_pkg::*;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [20:0] progAddr;
  logic [15:0] progData;
  logic [11:0] dmemAddr;
  logic [7:0]  dmemRdData, dmemWrData;
  logic        dmemWrEn;
  logic [7:0]  expMem [0:4095];
  int          numErrors = 0, samplesChecked = 0, cycles = 0;

  always #50 clk = ~clk;

  eid_core #(.STACK_DEPTH(8)) i_eid_core (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .progAddr, .progData, .dmemAddr, .dmemRdData,
    .dmemWrData, .dmemWrEn);
  eid_mem_model i_eid_mem_model (.clk, .progAddr, .progData, .dmemAddr, .dmemRdData,
    .dmemWrData, .dmemWrEn);

  task automatic end_sim();
    $display("errors %0d checks %0d", numErrors, samplesChecked);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the two hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      numErrors++;
      end_sim();
    end
  end

  // Handshakes judged mid-cycle, signals moved only just after the edge
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awHs, wHs, bOk;
    logic [1:0] r;
    bOk = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bOk) begin
      @(negedge clk);
      awHs = s_axi_awvalid && s_axi_awready;
      wHs = s_axi_wvalid && s_axi_wready;
      bOk = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (awHs) s_axi_awvalid <= 1'h0;
      if (wHs) s_axi_wvalid <= 1'h0;
      s_axi_bready <= !bOk;
    end
    `CHK(r, er)
  endtask

  task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic arHs, rOk;
    logic [31:0] d;
    logic [1:0] r;
    rOk = 1'h0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!rOk) begin
      @(negedge clk);
      arHs = s_axi_arvalid && s_axi_arready;
      rOk = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (arHs) s_axi_arvalid <= 1'h0;
      s_axi_rready <= !rOk;
    end
    `CHK(d, ed)
    `CHK(r, er)
  endtask

  task automatic cmpMem();
    for (int i = 0; i < 4096; i++) `CHK(i_eid_mem_model.dmem[i], expMem[i])
  endtask

  task automatic clrProg();
    for (int i = 0; i < 1024; i++) i_eid_mem_model.prog[i] = 16'h0000;
  endtask

  initial begin
    logic [7:0]  a0, k1, k2, l1, l2, acc;
    logic [6:0]  zs, zs2, zd;
    logic [5:0]  kA, kS, kU;
    logic [3:0]  b;
    logic [11:0] p0, p1, p2;
    void'($urandom(47396));
    for (int i = 0; i < 4096; i++) begin
      i_eid_mem_model.dmem[i] = 8'($urandom);
      expMem[i] = i_eid_mem_model.dmem[i];
    end
    {a0, k1, k2, l1} = $urandom;
    {l2, zs, zs2, zd, kA} = 35'({$urandom, $urandom});
    {kS, kU, p0, p1} = 36'({$urandom, $urandom});
    b = 4'($urandom_range(14, 1));
    p2 = {4'h3, 8'($urandom)};
    i_eid_mem_model.dmem[{b, 8'h71}] = 8'h00;
    expMem[{b, 8'h71}] = 8'h00;
    i_eid_mem_model.dmem[{b, 8'h72}] |= 8'h01;
    expMem[{b, 8'h72}] |= 8'h01;
    clrProg();
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    axiRd(OFF_CTRL, 32'h0, RESP_OKAY);
    axiRd(8'h40, 32'h0, RESP_SLVERR);
    axiWr(OFF_STATUS, 32'h0, RESP_SLVERR);
    axiWr(OFF_ACC, {24'h0, a0}, RESP_OKAY);
    axiWr(OFF_BANK, {28'h0, b}, RESP_OKAY);
    axiWr(OFF_PTR0, {20'h0, p0}, RESP_OKAY);
    axiWr(OFF_PTR1, {20'h0, p1}, RESP_OKAY);
    axiWr(OFF_PTR2, {20'h0, p2}, RESP_OKAY);
    axiWr(OFF_LATCH, 32'h1, RESP_OKAY);
    // Program with the extended group on; expectations follow each word
    i_eid_mem_model.prog[0] = {OP_XOR_LIT, k1};
    acc = a0 ^ k1;
    i_eid_mem_model.prog[1] = {OP_XOR_FILE, 2'h3, 8'h70};
    expMem[{b, 8'h70}] ^= acc;
    i_eid_mem_model.prog[2] = {OP_TEST_SKIP, 1'h1, 8'h71};
    i_eid_mem_model.prog[3] = {OP_MOVE_IDX, 1'h0, zs};
    i_eid_mem_model.prog[4] = {PFX_SECOND, 12'h0C1};
    i_eid_mem_model.prog[5] = {OP_TEST_SKIP, 1'h1, 8'h72};
    i_eid_mem_model.prog[6] = {OP_XOR_LIT, k2};
    acc ^= k2;
    i_eid_mem_model.prog[7] = {OP_PTR_ADD, 2'h0, kA};
    i_eid_mem_model.prog[8] = {OP_PTR_SUB, 2'h1, kS};
    i_eid_mem_model.prog[9] = {OP_PUSH_LIT, l1};
    expMem[p2] = l1;
    p2 -= 12'h001;
    i_eid_mem_model.prog[10] = {OP_MOVE_IDX, 1'h0, zs};
    i_eid_mem_model.prog[11] = {PFX_SECOND, 12'h0C0};
    expMem[12'h0C0] = expMem[p2 + 12'(zs)];
    i_eid_mem_model.prog[12] = {OP_MOVE_IDX, 1'h1, zs2};
    i_eid_mem_model.prog[13] = {PFX_SECOND, 5'h00, zd};
    expMem[p2 + 12'(zd)] = expMem[p2 + 12'(zs2)];
    i_eid_mem_model.prog[14] = {OP_XOR_FILE, 3'h0, INDEXED_MAX[6:0]};
    acc ^= expMem[p2 + 12'(INDEXED_MAX)];
    i_eid_mem_model.prog[15] = OP_CALL_ACC;
    i_eid_mem_model.prog[{1'h1, acc[7:1]}] = {OP_PTR_ADD, SEL_STACK, kU};
    p2 += 12'(kU);
    i_eid_mem_model.prog[16] = {OP_PUSH_LIT, l2};
    expMem[p2] = l2;
    p2 -= 12'h001;
    axiWr(OFF_CTRL, 32'h3, RESP_OKAY);
    repeat (40) @(posedge clk);
    axiWr(OFF_CTRL, 32'h1, RESP_OKAY);
    axiRd(OFF_ACC, {24'h0, acc}, RESP_OKAY);
    axiRd(OFF_STATUS, {30'h0, acc[7], acc == 8'h00}, RESP_OKAY);
    axiRd(OFF_PTR0, {20'h0, p0 + 12'(kA)}, RESP_OKAY);
    axiRd(OFF_PTR1, {20'h0, p1 - 12'(kS)}, RESP_OKAY);
    axiRd(OFF_PTR2, {20'h0, p2}, RESP_OKAY);
    cmpMem();
    // Reset with the core stopped, then the same opcodes with the group off
    srst <= 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    axiRd(OFF_CTRL, 32'h0, RESP_OKAY);
    clrProg();
    {a0, k1, l1} = 24'($urandom);
    p2 = {4'h5, 8'($urandom)};
    i_eid_mem_model.prog[0] = {OP_PUSH_LIT, l1};
    i_eid_mem_model.prog[1] = {OP_PTR_ADD, 2'h2, 6'h3F};
    i_eid_mem_model.prog[2] = {OP_XOR_FILE, 2'h2, 8'h10};
    expMem[{ACCESS_LOBNK, 8'h10}] ^= a0;
    i_eid_mem_model.prog[3] = {OP_XOR_LIT, k1};
    acc = a0 ^ k1;
    axiWr(OFF_ACC, {24'h0, a0}, RESP_OKAY);
    axiWr(OFF_PTR2, {20'h0, p2}, RESP_OKAY);
    axiWr(OFF_CTRL, 32'h2, RESP_OKAY);
    repeat (20) @(posedge clk);
    axiWr(OFF_CTRL, 32'h0, RESP_OKAY);
    axiRd(OFF_ACC, {24'h0, acc}, RESP_OKAY);
    axiRd(OFF_STATUS, {30'h0, acc[7], acc == 8'h00}, RESP_OKAY);
    axiRd(OFF_PTR2, {20'h0, p2}, RESP_OKAY);
    cmpMem();
    // Indexed moves that touch the indirect access registers
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    clrProg();
    i_eid_mem_model.prog[0] = {OP_MOVE_IDX, 1'h1, 7'h6F};
    i_eid_mem_model.prog[1] = {PFX_SECOND, 5'h00, 7'h10};
    expMem[12'hF90] = 8'h00;
    i_eid_mem_model.prog[2] = {OP_MOVE_IDX, 1'h1, 7'h11};
    i_eid_mem_model.prog[3] = {PFX_SECOND, 5'h00, 7'h67};
    axiWr(OFF_PTR2, 32'h00000F80, RESP_OKAY);
    axiWr(OFF_CTRL, 32'h3, RESP_OKAY);
    repeat (10) @(posedge clk);
    axiWr(OFF_CTRL, 32'h0, RESP_OKAY);
    cmpMem();
    end_sim();
  end
endmodule

bind eid_core eid_core_props #(.STACK_DEPTH(STACK_DEPTH)) i_eid_core_props (.clk, .srst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .progAddr, .progData, .dmemRdData, .dmemWrData, .dmemWrEn);
